// [design/spm_map.svh]
/*
  Holds the address map, field positions, reset values and sizes of the serial and trigger pin sharing block.
  Assumes it is included by its bare name from the package and the design modules.
*/
// Operation
// - Clock pin: port when off, clock when on
// - External clock only in input, external mode
// - Channel 2 data pin: port or serial data
// - Second unit data pin: port or data
// - Receive pins stay ports, always sampled
// - Clear-to-send sampled when enabled, port stays
// - Trigger pin read when trigger enabled
// - Input-shared port bits always usable
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

`define SPM_ADDR_W 8
`define SPM_DATA_W 32
`define SPM_NUM_PINS 9
`define SPM_NUM_FUNC 10

`define SPM_ADDR_PORT_DATA 8'h00
`define SPM_ADDR_PORT_DIR 8'h04
`define SPM_ADDR_FUNC_CTRL 8'h08
`define SPM_ADDR_PIN_LEVEL 8'h0c

`define SPM_RST_PORT_DATA 9'h000
`define SPM_RST_PORT_DIR 9'h000
`define SPM_RST_FUNC_CTRL 10'h000

// Pin positions in the port vectors.
`define SPM_PIN_B5 0
`define SPM_PIN_B6 1
`define SPM_PIN_B7 2
`define SPM_PIN_C0 3
`define SPM_PIN_C1 4
`define SPM_PIN_C2 5
`define SPM_PIN_C3 6
`define SPM_PIN_C4 7
`define SPM_PIN_C5 8

// Field positions in the function control register.
`define SPM_F_CLK_OUT_CH1 0
`define SPM_F_CLK_OUT_CH2 1
`define SPM_F_CLK_OUT_U2 2
`define SPM_F_TXD_CH2 3
`define SPM_F_TXD_U2 4
`define SPM_F_EXT_CLK_CH1 5
`define SPM_F_EXT_CLK_CH2 6
`define SPM_F_EXT_CLK_U2 7
`define SPM_F_CTS_CH0 8
`define SPM_F_TRIG 9

`endif

// [design/spm_pkg.sv]
/*
  Holds the shared types of the pin sharing block.
  Assumes spm_map.svh is on the include path.
*/
`include "spm_map.svh"

package spm_pkg;
    typedef logic [`SPM_NUM_PINS-1:0] spm_pins_t;
    typedef logic [`SPM_NUM_FUNC-1:0] spm_func_t;
    typedef logic [`SPM_ADDR_W-1:0] spm_addr_t;
    typedef logic [`SPM_DATA_W-1:0] spm_word_t;
endpackage : spm_pkg

// [design/spm_pin_cell.sv]
/*
  Holds one multifunction pin cell that selects between port and peripheral output.
  Assumes the pin input is synchronous to pclk and that the peripheral output arrives on pclk.
*/
`timescale 1ns/1ps

module spm_pin_cell (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Port and peripheral controls
    input wire logic port_data,
    input wire logic port_dir,
    input wire logic periph_en,
    input wire logic periph_out,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_level
);
    wire logic out_d;
    wire logic oe_d;

    // A peripheral output wins; otherwise only the port bits steer the driver.
    assign out_d = periph_en ? periph_out : port_data;
    assign oe_d = periph_en | port_dir;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            pin_out <= out_d;
            pin_oe <= oe_d;
            pin_level <= pin_in;
        end
    end
endmodule : spm_pin_cell

// [design/spm_apb_regs.sv]
/*
  Holds the APB register file: port data, port direction, function control and pin level.
  Assumes an APB master on pclk; answers with no wait states.
*/
`timescale 1ns/1ps
`include "spm_map.svh"

module spm_apb_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire spm_pkg::spm_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire spm_pkg::spm_word_t pwdata,
    output spm_pkg::spm_word_t prdata,
    output logic pready,
    output logic pslverr,
    // Register contents
    input wire spm_pkg::spm_pins_t pin_level,
    output spm_pkg::spm_pins_t port_data_q,
    output spm_pkg::spm_pins_t port_dir_q,
    output spm_pkg::spm_func_t func_q
);
    function automatic logic hit(input spm_pkg::spm_addr_t a, input spm_pkg::spm_addr_t r);
        hit = (a == r);
    endfunction : hit

    wire logic setup_w;
    wire logic wr_w;
    wire logic mapped_w;
    wire spm_pkg::spm_word_t rd_w;

    assign setup_w = psel & ~penable;
    assign wr_w = psel & penable & pwrite;
    assign mapped_w = hit(paddr, `SPM_ADDR_PORT_DATA) | hit(paddr, `SPM_ADDR_PORT_DIR) |
                      hit(paddr, `SPM_ADDR_FUNC_CTRL) | hit(paddr, `SPM_ADDR_PIN_LEVEL);
    assign rd_w = hit(paddr, `SPM_ADDR_PORT_DATA) ? {23'h000000, port_data_q} :
                  hit(paddr, `SPM_ADDR_PORT_DIR) ? {23'h000000, port_dir_q} :
                  hit(paddr, `SPM_ADDR_FUNC_CTRL) ? {22'h000000, func_q} :
                  hit(paddr, `SPM_ADDR_PIN_LEVEL) ? {23'h000000, pin_level} : 32'h00000000;

    // Read data and error are prepared in the setup cycle so they stand in the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_w) begin
                prdata <= pwrite ? 32'h00000000 : rd_w;
                pslverr <= ~mapped_w;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_q <= `SPM_RST_PORT_DATA;
            port_dir_q <= `SPM_RST_PORT_DIR;
            func_q <= `SPM_RST_FUNC_CTRL;
        end else if (wr_w) begin
            if (hit(paddr, `SPM_ADDR_PORT_DATA)) port_data_q <= pwdata[`SPM_NUM_PINS-1:0];
            if (hit(paddr, `SPM_ADDR_PORT_DIR)) port_dir_q <= pwdata[`SPM_NUM_PINS-1:0];
            if (hit(paddr, `SPM_ADDR_FUNC_CTRL)) func_q <= pwdata[`SPM_NUM_FUNC-1:0];
        end
    end
endmodule : spm_apb_regs

// [design/spm_pin_mux.sv]
/*
  Holds the top of the serial and trigger pin sharing block: nine shared pins, the serial and
  timer hookups and the APB register file.
  Assumes the serial units and the pulse timer run on pclk and that pin inputs are synchronous.
*/
`timescale 1ns/1ps
`include "spm_map.svh"

module spm_pin_mux (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire spm_pkg::spm_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire spm_pkg::spm_word_t pwdata,
    output spm_pkg::spm_word_t prdata,
    output logic pready,
    output logic pslverr,
    // Serial unit outputs toward the pins
    input wire logic uart_clk_out_ch1,
    input wire logic uart_clk_out_ch2,
    input wire logic uart_clk_out_unit2,
    input wire logic uart_txd_ch2,
    input wire logic uart_txd_unit2,
    // Pin inputs toward the serial units and the timer
    output logic serial_clk_ch1_ext,
    output logic serial_clk_ch2_ext,
    output logic serial_clk_unit2_ext,
    output logic serial_rxd_ch2,
    output logic serial_rxd_unit2,
    output logic clear_to_send_ch0,
    output logic pulse_timer_trigger_in,
    // Pin port_b_bit5
    input wire logic port_b_bit5_in,
    output logic port_b_bit5_out,
    output logic port_b_bit5_oe,
    // Pin port_b_bit6
    input wire logic port_b_bit6_in,
    output logic port_b_bit6_out,
    output logic port_b_bit6_oe,
    // Pin port_b_bit7
    input wire logic port_b_bit7_in,
    output logic port_b_bit7_out,
    output logic port_b_bit7_oe,
    // Pin port_c_bit0
    input wire logic port_c_bit0_in,
    output logic port_c_bit0_out,
    output logic port_c_bit0_oe,
    // Pin port_c_bit1
    input wire logic port_c_bit1_in,
    output logic port_c_bit1_out,
    output logic port_c_bit1_oe,
    // Pin port_c_bit2
    input wire logic port_c_bit2_in,
    output logic port_c_bit2_out,
    output logic port_c_bit2_oe,
    // Pin port_c_bit3
    input wire logic port_c_bit3_in,
    output logic port_c_bit3_out,
    output logic port_c_bit3_oe,
    // Pin port_c_bit4
    input wire logic port_c_bit4_in,
    output logic port_c_bit4_out,
    output logic port_c_bit4_oe,
    // Pin port_c_bit5
    input wire logic port_c_bit5_in,
    output logic port_c_bit5_out,
    output logic port_c_bit5_oe
);
    spm_pkg::spm_pins_t port_data_q;
    spm_pkg::spm_pins_t port_dir_q;
    spm_pkg::spm_func_t func_q;
    spm_pkg::spm_pins_t pin_level;
    spm_pkg::spm_pins_t pin_out_w;
    spm_pkg::spm_pins_t pin_oe_w;
    wire spm_pkg::spm_pins_t pin_in_w;
    wire spm_pkg::spm_pins_t periph_en_w;
    wire spm_pkg::spm_pins_t periph_out_w;
    wire logic ext_ch1_d;
    wire logic ext_ch2_d;
    wire logic ext_u2_d;
    wire logic cts_d;
    wire logic trig_d;

    spm_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .pin_level(pin_level),
        .port_data_q(port_data_q),
        .port_dir_q(port_dir_q),
        .func_q(func_q)
    );

    assign pin_in_w = {port_c_bit5_in, port_c_bit4_in, port_c_bit3_in, port_c_bit2_in, port_c_bit1_in,
                       port_c_bit0_in, port_b_bit7_in, port_b_bit6_in, port_b_bit5_in};

    // Output functions per pin; the input-only pins never get a peripheral driver.
    assign periph_en_w[`SPM_PIN_B5] = func_q[`SPM_F_CLK_OUT_CH1];
    assign periph_en_w[`SPM_PIN_B6] = func_q[`SPM_F_TXD_CH2];
    assign periph_en_w[`SPM_PIN_B7] = 1'b0;
    assign periph_en_w[`SPM_PIN_C0] = func_q[`SPM_F_CLK_OUT_CH2];
    assign periph_en_w[`SPM_PIN_C1] = func_q[`SPM_F_TXD_U2];
    assign periph_en_w[`SPM_PIN_C2] = 1'b0;
    assign periph_en_w[`SPM_PIN_C3] = func_q[`SPM_F_CLK_OUT_U2];
    assign periph_en_w[`SPM_PIN_C4] = 1'b0;
    assign periph_en_w[`SPM_PIN_C5] = 1'b0;

    assign periph_out_w[`SPM_PIN_B5] = uart_clk_out_ch1;
    assign periph_out_w[`SPM_PIN_B6] = uart_txd_ch2;
    assign periph_out_w[`SPM_PIN_B7] = 1'b0;
    assign periph_out_w[`SPM_PIN_C0] = uart_clk_out_ch2;
    assign periph_out_w[`SPM_PIN_C1] = uart_txd_unit2;
    assign periph_out_w[`SPM_PIN_C2] = 1'b0;
    assign periph_out_w[`SPM_PIN_C3] = uart_clk_out_unit2;
    assign periph_out_w[`SPM_PIN_C4] = 1'b0;
    assign periph_out_w[`SPM_PIN_C5] = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < `SPM_NUM_PINS; gi = gi + 1) begin : g_pin
            spm_pin_cell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .port_data(port_data_q[gi]),
                .port_dir(port_dir_q[gi]),
                .periph_en(periph_en_w[gi]),
                .periph_out(periph_out_w[gi]),
                .pin_in(pin_in_w[gi]),
                .pin_out(pin_out_w[gi]),
                .pin_oe(pin_oe_w[gi]),
                .pin_level(pin_level[gi])
            );
        end
    endgenerate

    assign port_b_bit5_out = pin_out_w[`SPM_PIN_B5];
    assign port_b_bit5_oe = pin_oe_w[`SPM_PIN_B5];
    assign port_b_bit6_out = pin_out_w[`SPM_PIN_B6];
    assign port_b_bit6_oe = pin_oe_w[`SPM_PIN_B6];
    assign port_b_bit7_out = pin_out_w[`SPM_PIN_B7];
    assign port_b_bit7_oe = pin_oe_w[`SPM_PIN_B7];
    assign port_c_bit0_out = pin_out_w[`SPM_PIN_C0];
    assign port_c_bit0_oe = pin_oe_w[`SPM_PIN_C0];
    assign port_c_bit1_out = pin_out_w[`SPM_PIN_C1];
    assign port_c_bit1_oe = pin_oe_w[`SPM_PIN_C1];
    assign port_c_bit2_out = pin_out_w[`SPM_PIN_C2];
    assign port_c_bit2_oe = pin_oe_w[`SPM_PIN_C2];
    assign port_c_bit3_out = pin_out_w[`SPM_PIN_C3];
    assign port_c_bit3_oe = pin_oe_w[`SPM_PIN_C3];
    assign port_c_bit4_out = pin_out_w[`SPM_PIN_C4];
    assign port_c_bit4_oe = pin_oe_w[`SPM_PIN_C4];
    assign port_c_bit5_out = pin_out_w[`SPM_PIN_C5];
    assign port_c_bit5_oe = pin_oe_w[`SPM_PIN_C5];

    // An external clock is passed only while the pin is an input and the channel is in external mode.
    assign ext_ch1_d = pin_in_w[`SPM_PIN_B5] & ~port_dir_q[`SPM_PIN_B5] & func_q[`SPM_F_EXT_CLK_CH1];
    assign ext_ch2_d = pin_in_w[`SPM_PIN_C0] & ~port_dir_q[`SPM_PIN_C0] & func_q[`SPM_F_EXT_CLK_CH2];
    assign ext_u2_d = pin_in_w[`SPM_PIN_C3] & ~port_dir_q[`SPM_PIN_C3] & func_q[`SPM_F_EXT_CLK_U2];
    assign cts_d = pin_in_w[`SPM_PIN_C4] & func_q[`SPM_F_CTS_CH0];
    assign trig_d = pin_in_w[`SPM_PIN_C5] & func_q[`SPM_F_TRIG];

    // The receive, clear-to-send and trigger levels reach the peripherals whatever the port bits do, so a driven pin reads back too.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_clk_ch1_ext <= 1'b0;
            serial_clk_ch2_ext <= 1'b0;
            serial_clk_unit2_ext <= 1'b0;
            serial_rxd_ch2 <= 1'b0;
            serial_rxd_unit2 <= 1'b0;
            clear_to_send_ch0 <= 1'b0;
            pulse_timer_trigger_in <= 1'b0;
        end else begin
            serial_clk_ch1_ext <= ext_ch1_d;
            serial_clk_ch2_ext <= ext_ch2_d;
            serial_clk_unit2_ext <= ext_u2_d;
            serial_rxd_ch2 <= pin_in_w[`SPM_PIN_B7];
            serial_rxd_unit2 <= pin_in_w[`SPM_PIN_C2];
            clear_to_send_ch0 <= cts_d;
            pulse_timer_trigger_in <= trig_d;
        end
    end

    // Helper that marks when the previous cycle was out of reset.
    logic past_ok_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            past_ok_q <= 1'b0;
        end else begin
            past_ok_q <= 1'b1;
        end
    end

    clk_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && func_q[`SPM_F_CLK_OUT_CH1] |=> port_b_bit5_oe && port_b_bit5_out == $past(uart_clk_out_ch1))
        else $error("clock pin of channel 1 not driving the serial clock");

    clk_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && !func_q[`SPM_F_CLK_OUT_U2] |=>
        port_c_bit3_oe == $past(port_dir_q[`SPM_PIN_C3]) && port_c_bit3_out == $past(port_data_q[`SPM_PIN_C3]))
        else $error("clock pin of the second unit not acting as a port bit");

    ext_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && (port_dir_q[`SPM_PIN_C0] || !func_q[`SPM_F_EXT_CLK_CH2]) |=> !serial_clk_ch2_ext)
        else $error("external clock of channel 2 passed while not selected");

    ext_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && !port_dir_q[`SPM_PIN_B5] && func_q[`SPM_F_EXT_CLK_CH1] ##1 past_ok_q |->
        serial_clk_ch1_ext == $past(port_b_bit5_in))
        else $error("external clock of channel 1 not following the pin");

    txd_ch2_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> port_b_bit6_out == ($past(func_q[`SPM_F_TXD_CH2]) ? $past(uart_txd_ch2) :
        $past(port_data_q[`SPM_PIN_B6])))
        else $error("data pin of channel 2 carries the wrong source");

    txd_unit2_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(func_q[`SPM_F_TXD_U2]) |=> port_c_bit1_oe)
        else $error("data pin of the second unit not driven after enable");

    rxd_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> serial_rxd_unit2 == $past(port_c_bit2_in) && serial_rxd_ch2 == $past(port_b_bit7_in))
        else $error("receive input not following its pin");

    cts_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> clear_to_send_ch0 == ($past(port_c_bit4_in) && $past(func_q[`SPM_F_CTS_CH0])))
        else $error("clear-to-send input wrong");

    trig_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> pulse_timer_trigger_in == ($past(port_c_bit5_in) && $past(func_q[`SPM_F_TRIG])))
        else $error("timer trigger input wrong");

    input_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> port_c_bit4_oe == $past(port_dir_q[`SPM_PIN_C4]) &&
        port_c_bit5_out == $past(port_data_q[`SPM_PIN_C5]))
        else $error("input-shared port bit not usable as a port");

    out_priority_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && func_q[`SPM_F_CLK_OUT_CH2] && !port_dir_q[`SPM_PIN_C0] |=>
        port_c_bit0_oe && port_c_bit0_out == $past(uart_clk_out_ch2))
        else $error("peripheral output enable lost to the port bits");

    // Port fallbacks, peripheral drives, input gates and the pin level register for the remaining pins.
    clk_port_ch1_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && !func_q[`SPM_F_CLK_OUT_CH1] |=> port_b_bit5_oe == $past(port_dir_q[`SPM_PIN_B5]))
        else $error("clock pin of channel 1 not acting as a port bit");

    clk_port_ch2_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && !func_q[`SPM_F_CLK_OUT_CH2] |=> port_c_bit0_out == $past(port_data_q[`SPM_PIN_C0]))
        else $error("clock pin of channel 2 not acting as a port bit");

    clk_drive_u2_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && func_q[`SPM_F_CLK_OUT_U2] |=> port_c_bit3_oe && port_c_bit3_out == $past(uart_clk_out_unit2))
        else $error("clock pin of the second unit not driving the serial clock");

    ext_gate_ch1_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && (port_dir_q[`SPM_PIN_B5] || !func_q[`SPM_F_EXT_CLK_CH1]) |=> !serial_clk_ch1_ext)
        else $error("external clock of channel 1 passed while not selected");

    ext_gate_u2_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && (port_dir_q[`SPM_PIN_C3] || !func_q[`SPM_F_EXT_CLK_U2]) |=> !serial_clk_unit2_ext)
        else $error("external clock of the second unit passed while not selected");

    ext_pass_u2_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q && !port_dir_q[`SPM_PIN_C3] && func_q[`SPM_F_EXT_CLK_U2] |=>
        serial_clk_unit2_ext == $past(port_c_bit3_in))
        else $error("external clock of the second unit not following the pin");

    txd_oe_ch2_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> port_b_bit6_oe == ($past(func_q[`SPM_F_TXD_CH2]) || $past(port_dir_q[`SPM_PIN_B6])))
        else $error("data pin of channel 2 has the wrong driver enable");

    txd_port_u2_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> port_c_bit1_out == ($past(func_q[`SPM_F_TXD_U2]) ? $past(uart_txd_unit2) :
        $past(port_data_q[`SPM_PIN_C1])))
        else $error("data pin of the second unit carries the wrong source");

    rxd_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> port_b_bit7_oe == $past(port_dir_q[`SPM_PIN_B7]) &&
        port_c_bit2_out == $past(port_data_q[`SPM_PIN_C2]))
        else $error("receive pin not usable as a port bit");

    cts_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> port_c_bit4_out == $past(port_data_q[`SPM_PIN_C4]))
        else $error("clear-to-send pin not usable as a port bit");

    trig_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> port_c_bit5_oe == $past(port_dir_q[`SPM_PIN_C5]))
        else $error("trigger pin not usable as a port bit");

    pin_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        past_ok_q |=> pin_level == $past(pin_in_w))
        else $error("pin level register not following the pins");
endmodule : spm_pin_mux

// [verif/spm_pin_partner.sv]
/*
  Holds a model of the external devices that face the nine shared pins.
  Assumes the bench sets which pins the far side drives and to what level.
*/
`timescale 1ns/1ps

module spm_pin_partner (
    // Clock
    input wire logic pclk,
    // Design pin drive
    input wire spm_pkg::spm_pins_t pin_out,
    input wire spm_pkg::spm_pins_t pin_oe,
    // Far side drive
    input wire spm_pkg::spm_pins_t ext_drv,
    input wire spm_pkg::spm_pins_t ext_en,
    // Resolved pin level
    output spm_pkg::spm_pins_t pin_in
);
    spm_pkg::spm_pins_t last_q = '0;
    wire spm_pkg::spm_pins_t far_on = ~pin_oe & ext_en;
    wire spm_pkg::spm_pins_t floating = ~pin_oe & ~ext_en;

    // The far side yields wherever the design drives; a floating pin shows its inverted last level.
    assign pin_in = (pin_oe & pin_out) | (far_on & ext_drv) | (floating & ~last_q);

    always @(posedge pclk) begin
        last_q <= pin_in;
    end
endmodule : spm_pin_partner

// [verif/tb_serial_and_trigger_pin_sharing.sv]
/*
  Holds the self-checking bench of the pin sharing block.
  Assumes the design files and the partner model are compiled first.
*/
`timescale 1ns/1ps

module tb_serial_and_trigger_pin_sharing;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    spm_pkg::spm_addr_t paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    spm_pkg::spm_word_t pwdata = '0;
    spm_pkg::spm_word_t prdata;
    logic pready;
    logic pslverr;
    logic [4:0] uo = '0;
    logic [2:0] ext_clk;
    logic [3:0] in_o;
    spm_pkg::spm_pins_t pin_in;
    spm_pkg::spm_pins_t pin_out;
    spm_pkg::spm_pins_t pin_oe;
    spm_pkg::spm_pins_t ext_drv = '0;
    spm_pkg::spm_pins_t ext_en = '0;
    spm_pkg::spm_word_t rd;
    logic err;
    int n_mismatch = 0;
    int num_checks = 0;

    always #10 pclk = ~pclk;

    spm_pin_mux dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .uart_clk_out_ch1(uo[0]), .uart_clk_out_ch2(uo[1]), .uart_clk_out_unit2(uo[2]),
        .uart_txd_ch2(uo[3]), .uart_txd_unit2(uo[4]),
        .serial_clk_ch1_ext(ext_clk[0]), .serial_clk_ch2_ext(ext_clk[1]), .serial_clk_unit2_ext(ext_clk[2]),
        .serial_rxd_ch2(in_o[0]), .serial_rxd_unit2(in_o[1]), .clear_to_send_ch0(in_o[2]),
        .pulse_timer_trigger_in(in_o[3]),
        .port_b_bit5_in(pin_in[0]), .port_b_bit5_out(pin_out[0]), .port_b_bit5_oe(pin_oe[0]),
        .port_b_bit6_in(pin_in[1]), .port_b_bit6_out(pin_out[1]), .port_b_bit6_oe(pin_oe[1]),
        .port_b_bit7_in(pin_in[2]), .port_b_bit7_out(pin_out[2]), .port_b_bit7_oe(pin_oe[2]),
        .port_c_bit0_in(pin_in[3]), .port_c_bit0_out(pin_out[3]), .port_c_bit0_oe(pin_oe[3]),
        .port_c_bit1_in(pin_in[4]), .port_c_bit1_out(pin_out[4]), .port_c_bit1_oe(pin_oe[4]),
        .port_c_bit2_in(pin_in[5]), .port_c_bit2_out(pin_out[5]), .port_c_bit2_oe(pin_oe[5]),
        .port_c_bit3_in(pin_in[6]), .port_c_bit3_out(pin_out[6]), .port_c_bit3_oe(pin_oe[6]),
        .port_c_bit4_in(pin_in[7]), .port_c_bit4_out(pin_out[7]), .port_c_bit4_oe(pin_oe[7]),
        .port_c_bit5_in(pin_in[8]), .port_c_bit5_out(pin_out[8]), .port_c_bit5_oe(pin_oe[8])
    );

    spm_pin_partner far_side (
        .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv), .ext_en(ext_en), .pin_in(pin_in)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic w, input spm_pkg::spm_addr_t a, input spm_pkg::spm_word_t d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Lets the registered pin logic take up the last change.
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task automatic t_regs();
        check(pin_oe, 9'h000);
        for (int a = 0; a < 5; a++) begin
            apb(1'b0, 8'(a * 4), '0);
            check(err, a == 4);
            if (a < 3) check(rd, 32'h0);
        end
        apb(1'b1, 8'h10, 32'hffff_ffff);
        check(err, 1'b1);
        apb(1'b1, 8'h00, 32'hffff_ffff);
        apb(1'b0, 8'h00, '0);
        check(rd, 32'h0000_01ff);
        apb(1'b1, 8'h08, 32'hffff_ffff);
        apb(1'b0, 8'h08, '0);
        check(rd, 32'h0000_03ff);
        apb(1'b1, 8'h08, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_periph();
        int pidx[5] = '{0, 3, 6, 1, 4};
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h04, 32'h1ff);
            apb(1'b1, 8'h08, 32'h1 << k);
            @(posedge pclk);
            uo[k] <= 1'b1;
            settle();
            check(pin_oe[pidx[k]], 1'b1);
            check(pin_out[pidx[k]], 1'b1);
            @(posedge pclk);
            uo[k] <= 1'b0;
            apb(1'b1, 8'h00, 32'h1ff);
            settle();
            check(pin_out[pidx[k]], 1'b0);
            apb(1'b1, 8'h08, 32'h0);
            settle();
            check(pin_out[pidx[k]], 1'b1);
            apb(1'b1, 8'h04, 32'h0);
            settle();
            check(pin_oe[pidx[k]], 1'b0);
        end
        $display("test periph done");
    endtask : t_periph

    task automatic t_ext();
        int cp[3] = '{0, 3, 6};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 8'h04, 32'h0);
            apb(1'b1, 8'h08, 32'h20 << i);
            @(posedge pclk);
            ext_en <= 9'h1ff;
            ext_drv[cp[i]] <= 1'b1;
            settle();
            check(ext_clk[i], 1'b1);
            @(posedge pclk);
            ext_drv[cp[i]] <= 1'b0;
            settle();
            check(ext_clk[i], 1'b0);
            @(posedge pclk);
            ext_en[cp[i]] <= 1'b0;
            apb(1'b1, 8'h00, 32'h1ff);
            apb(1'b1, 8'h04, 32'h1 << cp[i]);
            settle();
            check(ext_clk[i], 1'b0);
            apb(1'b1, 8'h04, 32'h0);
            apb(1'b1, 8'h08, 32'h0);
            @(posedge pclk);
            ext_en <= 9'h1ff;
            ext_drv[cp[i]] <= 1'b1;
            settle();
            check(ext_clk[i], 1'b0);
        end
        $display("test ext clock done");
    endtask : t_ext

    task automatic t_inputs();
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        @(posedge pclk);
        ext_en <= 9'h1ff;
        ext_drv <= 9'h0a4;
        settle();
        check(in_o, 4'b0011);
        apb(1'b0, 8'h0c, '0);
        check(rd, 32'h0000_00a4);
        apb(1'b1, 8'h08, 32'h300);
        @(posedge pclk);
        ext_drv <= 9'h15b;
        settle();
        check(in_o, 4'b1000);
        @(posedge pclk);
        ext_drv <= 9'h1ff;
        settle();
        check(in_o, 4'b1111);
        @(posedge pclk);
        ext_en <= 9'h07f;
        apb(1'b1, 8'h00, 32'h100);
        apb(1'b1, 8'h04, 32'h180);
        settle();
        check(pin_oe, 9'h180);
        check(pin_out[8:7], 2'b10);
        check(in_o[3:2], 2'b10);
        $display("test inputs done");
    endtask : t_inputs

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        t_regs();
        t_periph();
        t_ext();
        t_inputs();
        results();
    end

    initial begin
        #200000;
        n_mismatch++;
        results();
    end
endmodule : tb_serial_and_trigger_pin_sharing
